// *** core/asuart_core.sv ***
// asynchronous serial core with apb registers
`timescale 1ns/10ps
module asuart_core (
  input wire logic CLK, // 250 MHz core clock
  input wire logic RSTN, // async reset, low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  output logic TXD, // serial data out
  input wire logic RXD, // serial data in
  output logic NRTS, // request to send, low
  input wire logic NCTS // clear to send, low
);
  // ===================================================================
  // declarations
  logic [1:0] mode_q, mode_d;
  logic [15:0] bint_q, bint_d;
  logic bfrac_q, bfrac_d;
  logic [6:0] cfg_q, cfg_d;
  logic ovf_q, ovf_d, perr_q, perr_d, ferr_q, ferr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [7:0] tacc_q, tacc_d;
  logic tick_q, tick_d;
  asuart_pkg::asu_tx_t tx_st_q, tx_st_d;
  logic [11:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d;
  logic [16:0] tx_cnt_q, tx_cnt_d;
  logic txd_q, txd_d, rts_q, rts_d;
  asuart_pkg::asu_rx_t rx_st_q, rx_st_d;
  logic [2:0] rxf_q, rxf_d;
  logic [16:0] rx_cnt_q, rx_cnt_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [3:0] rx_n_q, rx_n_d;
  logic en, done, acc_data, tx_push, rx_pop, tx_pop, rx_push, ovf_evt;
  logic [16:0] div;
  logic [3:0] nd, nbits;
  logic [7:0] tx_rdata;
  logic [9:0] rx_rdata, rx_wdata;
  logic tx_full, tx_empty, rx_full, rx_empty, maj;
  logic [2:0] tx_count, rx_count;

  assign en = (mode_q == asuart_pkg::MODE_UART);
  // bit time in 24 MHz ticks
  assign div = {bint_q, 1'b0} + {16'h0000, bfrac_q};
  assign nd = cfg_q[asuart_pkg::CFG_8BIT] ? 4'h8 : 4'h7;
  assign nbits = nd + {3'h0, cfg_q[asuart_pkg::CFG_PAR]};
  assign done = PSEL && PENABLE && pready_q;
  assign acc_data = done && (PADDR == asuart_pkg::ADDR_DATA);
  assign tx_push = acc_data && PWRITE && en;
  assign rx_pop = acc_data && !PWRITE;
  assign maj = (rxf_q[0] & rxf_q[1]) | (rxf_q[1] & rxf_q[2]) |
               (rxf_q[0] & rxf_q[2]);

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign TXD = txd_q;
  assign NRTS = rts_q;

  // ===================================================================
  // queues
  asuart_fifo #(.W(8)) u_txq (
    .clk(CLK), .rst_n(RSTN), .push(tx_push), .wdata(PWDATA[7:0]),
    .pop(tx_pop), .rdata(tx_rdata), .full(tx_full), .empty(tx_empty),
    .count(tx_count)
  );
  asuart_fifo #(.W(10)) u_rxq (
    .clk(CLK), .rst_n(RSTN), .push(rx_push), .wdata(rx_wdata),
    .pop(rx_pop), .rdata(rx_rdata), .full(rx_full), .empty(rx_empty),
    .count(rx_count)
  );

  // ===================================================================
  // apb registers
  always_comb begin
    mode_d = mode_q;
    bint_d = bint_q;
    bfrac_d = bfrac_q;
    cfg_d = cfg_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    // one wait state: ready rises after the first access cycle
    pready_d = PSEL && PENABLE && !pready_q;
    if (PSEL && PENABLE && !pready_q) begin
      prdata_d = 32'h0000_0000;
      if (PADDR == asuart_pkg::ADDR_MODE) begin
        prdata_d[1:0] = mode_q;
      end else if (PADDR == asuart_pkg::ADDR_DATA) begin
        prdata_d[7:0] = rx_rdata[7:0];
      end else if (PADDR == asuart_pkg::ADDR_BINT) begin
        prdata_d[15:0] = bint_q;
      end else if (PADDR == asuart_pkg::ADDR_BFRAC) begin
        prdata_d[0] = bfrac_q;
      end else if (PADDR == asuart_pkg::ADDR_CFG) begin
        prdata_d[6:0] = cfg_q;
      end else if (PADDR == asuart_pkg::ADDR_STAT) begin
        prdata_d[asuart_pkg::ST_CTS] = !NCTS;
        prdata_d[asuart_pkg::ST_RXVAL] = !rx_empty;
        prdata_d[asuart_pkg::ST_TXFREE] = !tx_full;
        prdata_d[asuart_pkg::ST_RXOVF] = ovf_q;
        prdata_d[asuart_pkg::ST_FRMERR] = ferr_q;
        prdata_d[asuart_pkg::ST_PARERR] = perr_q;
        prdata_d[asuart_pkg::ST_TXIDLE] = tx_empty && tx_st_q == 
                                          asuart_pkg::TX_IDLE;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (done && PWRITE) begin
      if (PADDR == asuart_pkg::ADDR_MODE) begin
        mode_d = PWDATA[1:0];
      end else if (PADDR == asuart_pkg::ADDR_BINT) begin
        bint_d = PWDATA[15:0];
      end else if (PADDR == asuart_pkg::ADDR_BFRAC) begin
        bfrac_d = PWDATA[0];
      end else if (PADDR == asuart_pkg::ADDR_CFG) begin
        cfg_d = PWDATA[6:0];
      end
    end
    // error flags follow the character just taken off the queue, and clear while the queue is empty
    perr_d = perr_q;
    ferr_d = ferr_q;
    if (rx_pop && !rx_empty) begin
      perr_d = rx_rdata[9];
      ferr_d = rx_rdata[8];
    end else if (rx_empty) begin
      perr_d = 1'b0;
      ferr_d = 1'b0;
    end
    // status read clears overrun; a new overrun in that cycle wins
    ovf_d = (ovf_q && !(done && !PWRITE &&
             PADDR == asuart_pkg::ADDR_STAT)) || ovf_evt;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= asuart_pkg::MODE_RST;
      bint_q <= asuart_pkg::BINT_RST;
      bfrac_q <= 1'b0;
      cfg_q <= asuart_pkg::CFG_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      bint_q <= bint_d;
      bfrac_q <= bfrac_d;
      cfg_q <= cfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      perr_q <= perr_d;
      ferr_q <= ferr_d;
      ovf_q <= ovf_d;
    end
  end

  // ===================================================================
  // 24 MHz tick from the 250 MHz clock by fractional accumulation
  always_comb begin
    logic [8:0] s;
    s = {1'b0, tacc_q} + {1'b0, asuart_pkg::TICK_STEP};
    tick_d = (s >= {1'b0, asuart_pkg::TICK_MOD});
    tacc_d = tick_d ? 8'(s - {1'b0, asuart_pkg::TICK_MOD}) : s[7:0];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tacc_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tacc_q <= tacc_d;
      tick_q <= tick_d;
    end
  end

  // ===================================================================
  // transmitter
  always_comb begin
    logic cts_ok, par;
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_cnt_d = tx_cnt_q;
    txd_d = txd_q;
    tx_pop = 1'b0;
    cts_ok = !cfg_q[asuart_pkg::CFG_FLOW] || !NCTS;
    par = ^(tx_rdata & (cfg_q[asuart_pkg::CFG_8BIT] ? 8'hff : 8'h7f)) ^
          cfg_q[asuart_pkg::CFG_ODD];
    case (tx_st_q)
      asuart_pkg::TX_IDLE: begin
        txd_d = 1'b1;
        if (en && !tx_empty && cts_ok) begin
          tx_pop = 1'b1;
          // start, data lsb first, parity, stop bits fill with ones
          tx_sh_d = 12'hfff;
          tx_sh_d[0] = 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (4'(i) < nd) begin
              tx_sh_d[i + 1] = tx_rdata[i];
            end
          end
          if (cfg_q[asuart_pkg::CFG_PAR]) begin
            tx_sh_d[nd + 4'h1] = par;
          end
          tx_left_d = 4'h2 + nbits +
                      {3'h0, cfg_q[asuart_pkg::CFG_2STP]};
          tx_cnt_d = 17'h0_0000;
          txd_d = 1'b0;
          tx_st_d = asuart_pkg::TX_SHIFT;
        end
      end
      asuart_pkg::TX_SHIFT: begin
        if (tick_q) begin
          if (tx_cnt_q >= div - 17'h0_0001) begin
            tx_cnt_d = 17'h0_0000;
            tx_sh_d = {1'b1, tx_sh_q[11:1]};
            tx_left_d = tx_left_q - 4'h1;
            txd_d = tx_sh_q[1];
            if (tx_left_q == 4'h1) begin
              txd_d = 1'b1;
              tx_st_d = asuart_pkg::TX_IDLE;
            end
          end else begin
            tx_cnt_d = tx_cnt_q + 17'h0_0001;
          end
        end
      end
      default: tx_st_d = asuart_pkg::TX_IDLE;
    endcase
    if (!en) begin
      tx_st_d = asuart_pkg::TX_IDLE;
      txd_d = 1'b1;
    end
    rts_d = cfg_q[asuart_pkg::CFG_AUTO] ?
            (rx_count > asuart_pkg::RTS_ROOM_LIMIT) :
            cfg_q[asuart_pkg::CFG_RTS];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_st_q <= asuart_pkg::TX_IDLE;
      tx_sh_q <= 12'hfff;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 17'h0_0000;
      txd_q <= 1'b1;
      rts_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_cnt_q <= tx_cnt_d;
      txd_q <= txd_d;
      rts_q <= rts_d;
    end
  end

  // ===================================================================
  // receiver: 3-sample majority at 24 MHz, sampled mid-bit
  always_comb begin
    logic [8:0] al;
    logic [7:0] dat;
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    rx_n_d = rx_n_q;
    rxf_d = tick_q ? {rxf_q[1:0], RXD} : rxf_q;
    rx_push = 1'b0;
    ovf_evt = 1'b0;
    al = rx_sh_q >> (4'h9 - nbits);
    dat = cfg_q[asuart_pkg::CFG_8BIT] ? al[7:0] : {1'b0, al[6:0]};
    rx_wdata = {cfg_q[asuart_pkg::CFG_PAR] && (al[nd] != (^dat ^
                cfg_q[asuart_pkg::CFG_ODD])), !maj, dat};
    case (rx_st_q)
      asuart_pkg::RX_IDLE: begin
        if (!maj) begin
          rx_cnt_d = 17'h0_0000;
          rx_st_d = asuart_pkg::RX_START;
        end
      end
      asuart_pkg::RX_START: begin
        if (tick_q) begin
          rx_cnt_d = rx_cnt_q + 17'h0_0001;
          if (rx_cnt_q >= {1'b0, div[16:1]}) begin
            rx_cnt_d = 17'h0_0000;
            rx_n_d = 4'h0;
            // high again at mid start: a glitch, not a character
            rx_st_d = maj ? asuart_pkg::RX_IDLE :
                            asuart_pkg::RX_BITS;
          end
        end
      end
      asuart_pkg::RX_BITS: begin
        if (tick_q) begin
          rx_cnt_d = rx_cnt_q + 17'h0_0001;
          if (rx_cnt_q >= div - 17'h0_0001) begin
            rx_cnt_d = 17'h0_0000;
            rx_sh_d = {maj, rx_sh_q[8:1]};
            rx_n_d = rx_n_q + 4'h1;
            if (rx_n_q + 4'h1 == nbits) begin
              rx_st_d = asuart_pkg::RX_STOP;
            end
          end
        end
      end
      asuart_pkg::RX_STOP: begin
        if (tick_q) begin
          rx_cnt_d = rx_cnt_q + 17'h0_0001;
          if (rx_cnt_q >= div - 17'h0_0001) begin
            // only one stop bit checked, whatever the tx setting
            rx_st_d = asuart_pkg::RX_IDLE;
            rx_push = !rx_full;
            ovf_evt = rx_full;
          end
        end
      end
      default: rx_st_d = asuart_pkg::RX_IDLE;
    endcase
    if (!en) begin
      rx_st_d = asuart_pkg::RX_IDLE;
      rx_push = 1'b0;
      ovf_evt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_st_q <= asuart_pkg::RX_IDLE;
      rxf_q <= 3'h7;
      rx_cnt_q <= 17'h0_0000;
      rx_sh_q <= 9'h000;
      rx_n_q <= 4'h0;
    end else begin
      rx_st_q <= rx_st_d;
      rxf_q <= rxf_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_n_q <= rx_n_d;
    end
  end

  // ===================================================================
  // checks
  a_mode_gate_idle: assert property (@(posedge CLK) disable iff (!RSTN)
    !en && $past(!en) |-> TXD && tx_st_q == asuart_pkg::TX_IDLE)
    else $error("line active while disabled");
  a_tick_rate_spacing: assert property (@(posedge CLK) disable iff (!RSTN)
    tick_q |=> !tick_q ##1 !tick_q ##1 !tick_q ##1 !tick_q ##1 !tick_q ##1
    !tick_q ##1 !tick_q ##1 !tick_q ##1 !tick_q)
    else $error("24 MHz tick too frequent");
  a_cts_gate_start: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(tx_st_q == asuart_pkg::TX_SHIFT) |->
    $past(!cfg_q[asuart_pkg::CFG_FLOW] || !NCTS))
    else $error("character started without clear");
  a_start_bit_low: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(tx_st_q == asuart_pkg::TX_SHIFT) |-> !TXD ##1 !TXD)
    else $error("frame did not open with a low start");
  a_frame_length: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(tx_st_q == asuart_pkg::TX_SHIFT) |->
    tx_left_q >= 4'h9 && tx_left_q <= 4'hc)
    else $error("frame length out of 9 to 12");
  a_rts_auto_room: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg_q[asuart_pkg::CFG_AUTO] && $stable(cfg_q) && rx_count <= 3'h2
    |=> !NRTS) else $error("request high with room for two");
  a_overrun_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    ovf_evt |-> !rx_push ##1 ovf_q)
    else $error("overrun not flagged or char stored");
  a_false_start: assert property (@(posedge CLK) disable iff (!RSTN)
    rx_st_q == asuart_pkg::RX_START && tick_q && maj &&
    rx_cnt_q >= {1'b0, div[16:1]} |=> rx_st_q == asuart_pkg::RX_IDLE)
    else $error("glitch accepted as start");
  a_pop_on_read: assert property (@(posedge CLK) disable iff (!RSTN)
    rx_pop && !rx_empty && !rx_push |=> rx_count == $past(rx_count) - 3'h1)
    else $error("data read did not pop receive queue");
endmodule

// *** core/asuart_fifo.sv ***
// four-entry character queue
`timescale 1ns/10ps
module asuart_fifo #(
  parameter int W = 10
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, low
  input wire logic push, // write strobe
  input wire logic [W-1:0] wdata, // entry written
  input wire logic pop, // read strobe
  output logic [W-1:0] rdata, // oldest entry
  output logic full, // no room left
  output logic empty, // nothing stored
  output logic [2:0] count // entries held
);
  logic [W-1:0] mem_q [4];
  logic [W-1:0] mem_d [4];
  logic [2:0] wp_q, wp_d, rp_q, rp_d;

  assign count = wp_q - rp_q;
  assign full = (count == asuart_pkg::FIFO_DEPTH);
  assign empty = (count == 3'h0);
  assign rdata = mem_q[rp_q[1:0]];

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (push && !full) begin
      mem_d[wp_q[1:0]] = wdata;
      wp_d = wp_q + 3'h1;
    end
    if (pop && !empty) begin
      rp_d = rp_q + 3'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[i] <= '0;
        end else begin
          mem_q[i] <= mem_d[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  a_depth_bound: assert property (@(posedge clk) disable iff (!rst_n)
    count <= 3'h4) else $error("queue holds more than four");
  a_push_when_full: assert property (@(posedge clk) disable iff (!rst_n)
    full && push && !pop |=> full && $stable(wp_q))
    else $error("push into full queue changed it");
endmodule

// *** core/asuart_pkg.sv ***
// constants and types of the asynchronous serial core
// =====================================================================
// Summary of operation
// - serial unit runs only while mode select holds the value 1
// - bit time is twice integer plus fraction, in 24 MHz ticks
// - integer and fraction parts come from their own registers
// - divisor range covers 300 bps up to 921.6 kbps
// - eight-bit select picks 8 data bits, else 7
// - transmitter sends one or two stop bits; receiver checks one
// - parity bit present on both paths only when parity enabled
// - even parity is xor of data, odd its inverse
// - frame is start, data lsb first, parity, then stop bits
// - frame length runs from 9 to 12 bit times
// - idle line is high; a low level begins the start bit
// - receiver filters noise and rejects false start bits
// - transmit and receive queues hold four characters each
// - data port write pushes transmit only while enabled, read pops receive queue
// - handshake drives request output; clear input gates sending
// - new character waits for clear low; one in flight finishes
// - auto request low while receive queue has room for two
// =====================================================================
package asuart_pkg;
  // ===================================================================
  // clocking
  localparam int CLK_MHZ = 250;
  localparam int REF_MHZ = 24;
  localparam logic [7:0] TICK_STEP = 8'(REF_MHZ);
  localparam logic [7:0] TICK_MOD = 8'(CLK_MHZ);
  // ===================================================================
  // register byte addresses
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;
  localparam logic [11:0] ADDR_BINT = 12'h008;
  localparam logic [11:0] ADDR_BFRAC = 12'h00c;
  localparam logic [11:0] ADDR_CFG = 12'h010;
  localparam logic [11:0] ADDR_STAT = 12'h014;
  // ===================================================================
  // line_config_register fields
  localparam int CFG_RTS = 0;
  localparam int CFG_8BIT = 1;
  localparam int CFG_2STP = 2;
  localparam int CFG_PAR = 3;
  localparam int CFG_ODD = 4;
  localparam int CFG_FLOW = 5;
  localparam int CFG_AUTO = 6;
  // status fields
  localparam int ST_CTS = 0;
  localparam int ST_RXVAL = 1;
  localparam int ST_TXFREE = 2;
  localparam int ST_RXOVF = 3;
  localparam int ST_FRMERR = 4;
  localparam int ST_PARERR = 5;
  localparam int ST_TXIDLE = 6;
  // ===================================================================
  // values
  localparam logic [1:0] MODE_UART = 2'h1;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] BINT_RST = 16'h0068;
  localparam logic [6:0] CFG_RST = 7'h00;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [2:0] RTS_ROOM_LIMIT = 3'h2;

  typedef enum logic {TX_IDLE, TX_SHIFT} asu_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} asu_rx_t;
endpackage

// *** tb/asu_peer.sv ***
// far-side serial device model for the uart core
`timescale 1ns/10ps
module asu_peer (
  input wire logic clk, // core clock
  output logic rxd, // drives core receive line
  input wire logic txd, // core transmit line
  output logic cts_n // clear to send, low
);
  int bit_cyc = 167; // bit time in core cycles
  int nbits = 10; // frame length, start to last stop
  logic [11:0] got_q[$]; // captured frames, bit0 is start
  realtime at_q[$]; // start edge times
  logic [11:0] sh;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  // ===================================================================
  // sender: each bit held a whole bit time, line back high after
  task automatic send(input logic [11:0] frm, input int n, input int cyc);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= frm[i];
      repeat (cyc - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // ===================================================================
  // capture: mid-bit samples timed from the falling start edge
  always begin
    @(negedge txd);
    at_q.push_back($realtime);
    sh = '1;
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      sh[i] = txd;
      if (i < nbits - 1) repeat (bit_cyc) @(posedge clk);
    end
    got_q.push_back(sh);
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the asynchronous serial core
`timescale 1ns/10ps
module testbench;
  localparam logic [11:0] A_MOD = asuart_pkg::ADDR_MODE;
  localparam logic [11:0] A_DAT = asuart_pkg::ADDR_DATA;
  localparam logic [11:0] A_ST = asuart_pkg::ADDR_STAT;
  localparam logic [11:0] A_CFG = asuart_pkg::ADDR_CFG;
  logic clk, rstn, psel, penable, pwrite, txd, nrts, pready, pslverr;
  logic err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire rxd, ncts;
  int num_errors = 0;
  int comparisons = 0;
  asuart_core DUT (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TXD(txd),
    .RXD(rxd), .NRTS(nrts), .NCTS(ncts));
  asu_peer peer (.clk(clk), .rxd(rxd), .txd(txd), .cts_n(ncts));
  // ===================================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ===================================================================
  // apb master: one idle edge before each setup avoids double drives
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // bounded wait for captured frames, or start edges when st is set
  task automatic waitn(input int n, input bit st);
    int k;
    k = 0;
    while ((st ? peer.at_q.size() : peer.got_q.size()) < n) begin
      @(posedge clk);
      k++;
      if (k > 30000) begin
        num_errors++;
        conclude();
      end
    end
  endtask
  // ===================================================================
  // expected wire frames
  function automatic logic [11:0] frame(input logic [7:0] d,
      input logic [6:0] c, input logic bad);
    logic [11:0] f;
    int k;
    k = c[1] ? 8 : 7;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < k; i++) f[i+1] = d[i];
    if (c[3]) f[k+1] = ^(d & (c[1] ? 8'hff : 8'h7f)) ^ c[4] ^ bad;
    return f;
  endfunction
  function automatic int flen(input logic [6:0] c);
    return 2 + (c[1] ? 8 : 7) + c[3] + c[2];
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ===================================================================
  // main sequence
  initial begin
    logic [6:0] cfgs [4];
    logic [6:0] c;
    int f;
    real bns;
    realtime gap;
    cfgs = '{7'h02, 7'h0c, 7'h1e, 7'h00};
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    check({nrts, txd}, 2'b11);
    rchk(A_MOD, 32'h0);
    rchk(asuart_pkg::ADDR_BINT, 32'h68);
    rchk(A_CFG, 32'h0);
    rchk(12'h0fc, 32'h0);
    check(err_seen, 1'b1);
    apb(1'b1, A_DAT, 32'h55);
    repeat (600) @(posedge clk);
    check(peer.got_q.size(), 0);
    rchk(A_ST, 32'h44);
    apb(1'b1, A_MOD, 32'h1);
    apb(1'b1, asuart_pkg::ADDR_BINT, 32'h8);
    // every data width, parity and stop option, two fractions
    foreach (cfgs[i]) begin
      c = cfgs[i];
      f = (i == 1);
      bns = (16 + f) * 1000.0 / asuart_pkg::REF_MHZ;
      peer.bit_cyc = int'(bns / 4.0);
      peer.nbits = flen(c);
      apb(1'b1, asuart_pkg::ADDR_BFRAC, 32'(f));
      apb(1'b1, A_CFG, 32'(c));
      apb(1'b1, A_DAT, 32'(8'ha5 ^ i));
      apb(1'b1, A_DAT, 32'(8'h3c + i));
      waitn(2, 1'b0);
      check(peer.got_q.pop_front(), frame(8'ha5 ^ i, c, 1'b0));
      check(peer.got_q.pop_front(), frame(8'h3c + i, c, 1'b0));
      gap = peer.at_q[1] - peer.at_q[0];
      // bit timing starts at an arbitrary tick phase: up to one tick short
      check(gap > flen(c) * bns - 1000.0 / asuart_pkg::REF_MHZ - 8 &&
            gap < flen(c) * bns + 12, 1);
      peer.at_q.delete();
      peer.send(frame(8'h96 + i, c, 1'b0), flen(c), peer.bit_cyc);
      repeat (20) @(posedge clk);
      rchk(A_DAT, 32'(c[1] ? 8'h96 + i : (8'h96 + i) & 8'h7f));
      rchk(A_ST, 32'h44);
    end
    // receive errors and a noise pulse
    c = 7'h0a;
    apb(1'b1, A_CFG, 32'(c));
    peer.send(frame(8'h5a, c, 1'b1), 11, 167);
    peer.send(frame(8'h33, c, 1'b0) & 12'h3ff, 11, 167);
    // a low stop bit needs an idle bit before the next start edge
    peer.send(12'hfff, 1, 167);
    peer.send(frame(8'h0f, c, 1'b0), 11, 167);
    peer.send(12'h0, 1, 20);
    repeat (400) @(posedge clk);
    rchk(A_DAT, 32'h5a);
    rchk(A_ST, 32'h66);
    rchk(A_DAT, 32'h33);
    rchk(A_ST, 32'h56);
    rchk(A_DAT, 32'h0f);
    rchk(A_ST, 32'h44);
    // receive queue depth, automatic request, overrun
    apb(1'b1, A_CFG, 32'h42);
    for (int i = 0; i < 5; i++) begin
      peer.send(frame(8'h20 + i, 7'h02, 1'b0), 10, 167);
      repeat (20) @(posedge clk);
      check(nrts, i >= 2);
    end
    rchk(A_ST, 32'h4e);
    rchk(A_ST, 32'h46);
    for (int i = 0; i < 4; i++) rchk(A_DAT, 32'h20 + i);
    apb(1'b1, A_CFG, 32'h03);
    repeat (4) @(posedge clk);
    check(nrts, 1'b1);
    apb(1'b1, A_CFG, 32'h22);
    repeat (4) @(posedge clk);
    check(nrts, 1'b0);
    // transmit queue depth and clear-to-send gating
    peer.nbits = 10;
    for (int i = 0; i < 5; i++) apb(1'b1, A_DAT, 32'h10 + i);
    rchk(A_ST, 32'h00);
    repeat (600) @(posedge clk);
    check(peer.at_q.size(), 0);
    peer.cts_n <= 1'b0;
    waitn(1, 1'b1);
    peer.cts_n <= 1'b1;
    repeat (3000) @(posedge clk);
    check(peer.got_q.size(), 1);
    check(peer.got_q.pop_front(), frame(8'h10, 7'h02, 1'b0));
    peer.cts_n <= 1'b0;
    waitn(3, 1'b0);
    repeat (3000) @(posedge clk);
    check(peer.got_q.size(), 3);
    for (int i = 1; i < 4; i++)
      check(peer.got_q.pop_front(), frame(8'h10 + i, 7'h02, 1'b0));
    conclude();
  end
endmodule
